// ---- logic/mprm_map.svh ----
// How it works
// - a rising power button edge leaves soft-off; its level alone does nothing
// - reset button is active low and only its falling edge requests reset
// - a held-low reset button never stretches reset; the pulse still ends
// - carrier reset for button, power fail, 12 V low, watchdog or software
// - supply drives power-good high; low power-good means not good and resets
// - suspend-imminent is asserted before any suspend begins
// - suspend-to-ram indicator is low for the whole suspend-to-ram state
// - suspend-to-disk indicator is unsupported and never asserted
// - soft-off indicator is asserted in soft-off and in no other state
// - first wake input takes pcie wakes, second takes general wakes
// - the external sensor asserts over-temp and the block latches it
// - thermal-trip output is low once the processor is in thermal shutdown
// - bus alert low raises a management interrupt or wakes, by configuration
// - four general outputs, four general inputs reading high when undriven
// - outputs hold bootstrap levels while the carrier reset is asserted
`ifndef MPRM_MAP_SVH
`define MPRM_MAP_SVH

`define MPRM_CLK_PERIOD_PS  4000
`define MPRM_RST_PULSE_NS   1000
`define MPRM_NOTICE_NS      200
`define MPRM_RST_CYCLES \
   ((`MPRM_RST_PULSE_NS*1000+`MPRM_CLK_PERIOD_PS-1)/`MPRM_CLK_PERIOD_PS)
`define MPRM_NOTICE_CYCLES \
   ((`MPRM_NOTICE_NS*1000+`MPRM_CLK_PERIOD_PS-1)/`MPRM_CLK_PERIOD_PS)
`define MPRM_CNT_W          8
`define MPRM_GP_W           4
`define MPRM_GPO_STRAP      4'hF
`define MPRM_GPO_RESET      4'hF
`define MPRM_ASYNC_W        13
`define MPRM_ASYNC_RESET    13'h1DFF

`endif

// ---- logic/mprm_pkg.sv ----
package mprm_pkg;

   typedef enum logic [1:0] {
      MPRM_OFF,
      MPRM_RUN,
      MPRM_NOTICE,
      MPRM_SLEEP
   } mprm_state_t;

   // pin-side asynchronous inputs, bundled for the synchroniser
   typedef struct packed {
      logic       power_button_n;
      logic       reset_button_n;
      logic       main_power_good;
      logic       vcc12_low;
      logic       pcie_wake_n;
      logic       general_wake_n;
      logic       battery_low_n;
      logic       overtemp_in_n;
      logic       mgmt_bus_alert_n;
      logic [3:0] gp_inputs;
   } mprm_async_t;

endpackage

// ---- logic/mprm_sync.sv ----
`timescale 1ns/1ps
`include "mprm_map.svh"
module mprm_sync
#(
   parameter int                        W       = `MPRM_ASYNC_W,
   parameter logic [`MPRM_ASYNC_W-1:0]  RST_VAL = `MPRM_ASYNC_RESET
)
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level_out
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] nxt_level;
   logic [W-1:0] level_ff;

   // a bit only moves once stages two and three agree
   always_comb
   begin
      for (int i = 0; i < W; i++)
         nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_ff  <= RST_VAL[W-1:0];
         s2_ff    <= RST_VAL[W-1:0];
         s3_ff    <= RST_VAL[W-1:0];
         level_ff <= RST_VAL[W-1:0];
      end
      else
      begin
         meta_ff  <= async_in;
         s2_ff    <= meta_ff;
         s3_ff    <= s2_ff;
         level_ff <= nxt_level;
      end
   end

   assign level_out = level_ff;

endmodule

// ---- logic/mprm_top.sv ----
`timescale 1ns/1ps
`include "mprm_map.svh"
module mprm_top
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  power_button_n,
   input  wire logic                  reset_button_n,
   input  wire logic                  main_power_good,
   input  wire logic                  vcc12_low,
   input  wire logic                  pcie_wake_n,
   input  wire logic                  general_wake_n,
   input  wire logic                  battery_low_n,
   input  wire logic                  overtemp_in_n,
   input  wire logic                  mgmt_bus_alert_n,
   input  wire logic [`MPRM_GP_W-1:0] gp_inputs,
   input  wire logic                  watchdog_timeout,
   input  wire logic                  sw_reset_req,
   input  wire logic                  sw_sleep_req,
   input  wire logic                  sw_off_req,
   input  wire logic                  cpu_shutdown,
   input  wire logic                  alert_wake_en,
   input  wire logic                  overtemp_clear,
   input  wire logic [`MPRM_GP_W-1:0] gp_out_value,
   output logic                       carrier_reset_out_n,
   output logic                       suspend_imminent_n,
   output logic                       suspend_ram_n,
   output logic                       suspend_disk_n,
   output logic                       soft_off_n,
   output logic                       thermal_trip_n,
   output logic                       mgmt_irq_n,
   output logic                       battery_low_flag,
   output logic                       overtemp_flag,
   output logic [`MPRM_GP_W-1:0]      gp_outputs,
   output logic [`MPRM_GP_W-1:0]      gp_in_level
);

   localparam logic [`MPRM_CNT_W-1:0] RST_CYC =
      `MPRM_CNT_W'(`MPRM_RST_CYCLES);
   localparam logic [`MPRM_CNT_W-1:0] NOTICE_CYC =
      `MPRM_CNT_W'(`MPRM_NOTICE_CYCLES);

   mprm_pkg::mprm_async_t raw_pins;
   mprm_pkg::mprm_async_t pins;

   mprm_pkg::mprm_state_t state_ff;
   mprm_pkg::mprm_state_t nxt_state;
   logic [`MPRM_CNT_W-1:0] rst_cnt_ff;
   logic [`MPRM_CNT_W-1:0] nxt_rst_cnt;
   logic [`MPRM_CNT_W-1:0] notice_cnt_ff;
   logic [`MPRM_CNT_W-1:0] nxt_notice_cnt;
   logic                   to_off_ff;
   logic                   nxt_to_off;
   logic [3:0]             prev_ff;
   logic [3:0]             nxt_prev;
   logic                   trip_meta_ff;
   logic                   trip_s2_ff;
   logic                   trip_s3_ff;
   logic                   trip_lvl_ff;
   logic                   nxt_trip_lvl;
   logic                   ot_flag_ff;
   logic                   nxt_ot_flag;
   logic                   pb_rise;
   logic                   rb_fall;
   logic                   w0_fall;
   logic                   w1_fall;
   logic                   alert_low;
   logic                   wake_any;
   logic                   power_fail;
   logic                   rst_cause;
   logic                   nxt_carrier_rst_n;
   logic                   carrier_rst_n_ff;
   logic                   nxt_imminent_n;
   logic                   imminent_n_ff;
   logic                   ram_n_ff;
   logic                   off_n_ff;
   logic                   trip_out_ff;
   logic                   irq_n_ff;
   logic                   batt_ff;
   logic [`MPRM_GP_W-1:0]  gpo_ff;
   logic [`MPRM_GP_W-1:0]  nxt_gpo;

   assign raw_pins = '{power_button_n   : power_button_n,
                       reset_button_n   : reset_button_n,
                       main_power_good  : main_power_good,
                       vcc12_low        : vcc12_low,
                       pcie_wake_n      : pcie_wake_n,
                       general_wake_n   : general_wake_n,
                       battery_low_n    : battery_low_n,
                       overtemp_in_n    : overtemp_in_n,
                       mgmt_bus_alert_n : mgmt_bus_alert_n,
                       gp_inputs        : gp_inputs};

   mprm_sync u_sync
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .async_in  (raw_pins),
      .level_out (pins)
   );

   // edges only from filtered levels
   assign pb_rise    = pins.power_button_n & ~prev_ff[0];
   assign rb_fall    = ~pins.reset_button_n & prev_ff[1];
   assign w0_fall    = ~pins.pcie_wake_n & prev_ff[2];
   assign w1_fall    = ~pins.general_wake_n & prev_ff[3];
   assign alert_low  = ~pins.mgmt_bus_alert_n;
   assign wake_any   = pb_rise | w0_fall | w1_fall
                     | (alert_low & alert_wake_en);
   // power-good low is a standing reset cause, not an edge
   assign power_fail = ~pins.main_power_good | pins.vcc12_low;
   // a held button adds nothing once its edge is consumed
   assign rst_cause  = rb_fall | watchdog_timeout | sw_reset_req;

   always_comb
   begin
      nxt_state      = state_ff;
      nxt_rst_cnt    = (rst_cnt_ff != '0) ? rst_cnt_ff - 1'b1 : rst_cnt_ff;
      nxt_notice_cnt = notice_cnt_ff;
      nxt_to_off     = to_off_ff;
      nxt_prev       = {pins.general_wake_n, pins.pcie_wake_n,
                        pins.reset_button_n, pins.power_button_n};
      unique case (state_ff)
         mprm_pkg::MPRM_OFF:
         begin
            if (pb_rise)
            begin
               nxt_state   = mprm_pkg::MPRM_RUN;
               nxt_rst_cnt = RST_CYC;
            end
         end
         mprm_pkg::MPRM_RUN:
         begin
            if (rst_cause)
               nxt_rst_cnt = RST_CYC;
            // low-power entry waits for any running reset to finish
            else if ((sw_sleep_req | sw_off_req) && rst_cnt_ff == '0
                     && !power_fail)
            begin
               nxt_state      = mprm_pkg::MPRM_NOTICE;
               nxt_notice_cnt = NOTICE_CYC;
               nxt_to_off     = sw_off_req;
            end
         end
         mprm_pkg::MPRM_NOTICE:
         begin
            nxt_notice_cnt = notice_cnt_ff - 1'b1;
            if (notice_cnt_ff == `MPRM_CNT_W'(1))
               nxt_state = to_off_ff ? mprm_pkg::MPRM_OFF
                                     : mprm_pkg::MPRM_SLEEP;
         end
         mprm_pkg::MPRM_SLEEP:
         begin
            if (wake_any)
            begin
               nxt_state   = mprm_pkg::MPRM_RUN;
               nxt_rst_cnt = RST_CYC;
            end
            else if (sw_off_req)
               nxt_state = mprm_pkg::MPRM_OFF;
         end
      endcase
   end

   always_comb
   begin
      // lpc devices stay out of reset during the notice so they can hear it
      nxt_carrier_rst_n = (nxt_state == mprm_pkg::MPRM_RUN
                        || nxt_state == mprm_pkg::MPRM_NOTICE)
                        && nxt_rst_cnt == '0 && !power_fail;
      nxt_imminent_n    = !(nxt_state == mprm_pkg::MPRM_NOTICE
                         || nxt_state == mprm_pkg::MPRM_SLEEP);
      // strap levels are driven while the carrier is held in reset
      nxt_gpo           = nxt_carrier_rst_n ? gp_out_value
                                            : `MPRM_GPO_STRAP;
      // a new over-temp event beats a clear in the same cycle
      nxt_ot_flag       = ~pins.overtemp_in_n
                        | (ot_flag_ff & ~overtemp_clear);
      nxt_trip_lvl      = (trip_s2_ff == trip_s3_ff) ? trip_s3_ff
                                                     : trip_lvl_ff;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff         <= mprm_pkg::MPRM_OFF;
         rst_cnt_ff       <= '0;
         notice_cnt_ff    <= '0;
         to_off_ff        <= 1'b0;
         prev_ff          <= 4'hF;
         trip_meta_ff     <= 1'b0;
         trip_s2_ff       <= 1'b0;
         trip_s3_ff       <= 1'b0;
         trip_lvl_ff      <= 1'b0;
         ot_flag_ff       <= 1'b0;
         carrier_rst_n_ff <= 1'b0;
         imminent_n_ff    <= 1'b1;
         ram_n_ff         <= 1'b1;
         off_n_ff         <= 1'b0;
         trip_out_ff      <= 1'b1;
         irq_n_ff         <= 1'b1;
         batt_ff          <= 1'b0;
         gpo_ff           <= `MPRM_GPO_RESET;
      end
      else
      begin
         state_ff         <= nxt_state;
         rst_cnt_ff       <= nxt_rst_cnt;
         notice_cnt_ff    <= nxt_notice_cnt;
         to_off_ff        <= nxt_to_off;
         prev_ff          <= nxt_prev;
         trip_meta_ff     <= cpu_shutdown;
         trip_s2_ff       <= trip_meta_ff;
         trip_s3_ff       <= trip_s2_ff;
         trip_lvl_ff      <= nxt_trip_lvl;
         ot_flag_ff       <= nxt_ot_flag;
         carrier_rst_n_ff <= nxt_carrier_rst_n;
         imminent_n_ff    <= nxt_imminent_n;
         ram_n_ff         <= nxt_state != mprm_pkg::MPRM_SLEEP;
         off_n_ff         <= nxt_state != mprm_pkg::MPRM_OFF;
         trip_out_ff      <= ~trip_lvl_ff;
         irq_n_ff         <= ~(alert_low & ~alert_wake_en);
         batt_ff          <= ~pins.battery_low_n;
         gpo_ff           <= nxt_gpo;
      end
   end

   assign carrier_reset_out_n = carrier_rst_n_ff;
   assign suspend_imminent_n  = imminent_n_ff;
   assign suspend_ram_n       = ram_n_ff;
   // no suspend-to-disk support: held deasserted
   assign suspend_disk_n      = 1'b1;
   assign soft_off_n          = off_n_ff;
   assign thermal_trip_n      = trip_out_ff;
   assign mgmt_irq_n          = irq_n_ff;
   assign battery_low_flag    = batt_ff;
   assign overtemp_flag       = ot_flag_ff;
   assign gp_outputs          = gpo_ff;
   // the pull-up is on the pin; undriven inputs arrive here high
   assign gp_in_level         = pins.gp_inputs;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_pb_leaves_off: assert property (
      state_ff == mprm_pkg::MPRM_OFF && pb_rise
      |=> state_ff == mprm_pkg::MPRM_RUN ##0 !carrier_reset_out_n)
      else $error("power button edge did not leave soft-off");
   a_button_resets: assert property (
      state_ff == mprm_pkg::MPRM_RUN && rb_fall
      |=> !carrier_reset_out_n [*8])
      else $error("reset button edge gave no reset pulse");
   a_reset_ends: assert property (
      state_ff == mprm_pkg::MPRM_RUN && rst_cnt_ff == `MPRM_CNT_W'(1)
      && !rst_cause && !power_fail && !sw_sleep_req && !sw_off_req
      |=> carrier_reset_out_n)
      else $error("reset pulse did not end");
   a_pgood_reset: assert property (
      !pins.main_power_good |=> !carrier_reset_out_n)
      else $error("power-good low without carrier reset");
   a_notice_first: assert property (
      $rose(state_ff == mprm_pkg::MPRM_SLEEP)
      |-> $past(!suspend_imminent_n, 2))
      else $error("suspend began without notice");
   a_ram_ind: assert property (
      (state_ff == mprm_pkg::MPRM_SLEEP) == !suspend_ram_n)
      else $error("suspend-to-ram indicator wrong");
   a_disk_never: assert property (
      suspend_disk_n)
      else $error("suspend-to-disk asserted");
   a_off_ind: assert property (
      (state_ff == mprm_pkg::MPRM_OFF) == !soft_off_n)
      else $error("soft-off indicator wrong");
   a_wake_sleep: assert property (
      state_ff == mprm_pkg::MPRM_SLEEP && (w0_fall || w1_fall)
      |=> state_ff == mprm_pkg::MPRM_RUN)
      else $error("wake input ignored in suspend");
   a_ot_sticky: assert property (
      ~pins.overtemp_in_n |=> overtemp_flag)
      else $error("over-temp not latched");
   a_trip_out: assert property (
      trip_lvl_ff |=> !thermal_trip_n)
      else $error("thermal trip not driven low");
   a_alert_irq: assert property (
      alert_low && !alert_wake_en |=> !mgmt_irq_n)
      else $error("alert raised no interrupt");
   a_strap_hold: assert property (
      !carrier_reset_out_n |-> gp_outputs == `MPRM_GPO_STRAP)
      else $error("strap levels lost during reset");

   c_power_up: cover property (
      state_ff == mprm_pkg::MPRM_OFF ##1 state_ff == mprm_pkg::MPRM_RUN);
   c_sleep_wake: cover property (
      state_ff == mprm_pkg::MPRM_SLEEP ##1 state_ff == mprm_pkg::MPRM_RUN);
   c_button_reset: cover property (
      rb_fall && state_ff == mprm_pkg::MPRM_RUN);
   c_to_off: cover property (
      state_ff == mprm_pkg::MPRM_NOTICE ##1 state_ff == mprm_pkg::MPRM_OFF);

endmodule

// ---- verification/mprm_carrier_model.sv ----
`timescale 1ns/1ps
module mprm_carrier_model
(
   input  wire logic                  supply_ok,
   input  wire logic                  rail12_low,
   input  wire mprm_pkg::mprm_async_t pull_low,
   output mprm_pkg::mprm_async_t      pins
);
   // lines other than main_power_good and vcc12_low have carrier pull-ups: released means high, never the last value
   always_comb
   begin
      pins                 = mprm_pkg::mprm_async_t'(~pull_low);
      pins.main_power_good = supply_ok;
      pins.vcc12_low       = rail12_low;
   end
endmodule

// ---- verification/module_power_reset_manager_tb.sv ----
`timescale 1ns/1ps
`include "mprm_map.svh"
module module_power_reset_manager_tb;
   localparam int S_CARR = 0;
   localparam int S_RAM  = 1;
   localparam int S_SOFT = 2;
   localparam int RSTC   = `MPRM_RST_CYCLES;
   localparam int NOTC   = `MPRM_NOTICE_CYCLES;
   logic                  clk;
   logic                  reset_n;
   logic                  supply_ok;
   logic                  rail12_low;
   mprm_pkg::mprm_async_t drv_low;
   mprm_pkg::mprm_async_t pins;
   logic                  watchdog_timeout;
   logic                  sw_reset_req;
   logic                  sw_sleep_req;
   logic                  sw_off_req;
   logic                  cpu_shutdown;
   logic                  alert_wake_en;
   logic                  overtemp_clear;
   logic [3:0]            gp_out_value;
   logic                  carrier_reset_out_n;
   logic                  suspend_imminent_n;
   logic                  suspend_ram_n;
   logic                  suspend_disk_n;
   logic                  soft_off_n;
   logic                  thermal_trip_n;
   logic                  mgmt_irq_n;
   logic                  battery_low_flag;
   logic                  overtemp_flag;
   logic [3:0]            gp_outputs;
   logic [3:0]            gp_in_level;
   logic [3:0]            gp_old;
   int                    miscompares;
   int                    comparisons;
   int                    n;

   mprm_carrier_model i_mprm_carrier_model
   (
      .supply_ok  (supply_ok),
      .rail12_low (rail12_low),
      .pull_low   (drv_low),
      .pins       (pins)
   );

   mprm_top i_mprm_top
   (
      .clk                 (clk),
      .reset_n             (reset_n),
      .power_button_n      (pins.power_button_n),
      .reset_button_n      (pins.reset_button_n),
      .main_power_good     (pins.main_power_good),
      .vcc12_low           (pins.vcc12_low),
      .pcie_wake_n         (pins.pcie_wake_n),
      .general_wake_n      (pins.general_wake_n),
      .battery_low_n       (pins.battery_low_n),
      .overtemp_in_n       (pins.overtemp_in_n),
      .mgmt_bus_alert_n    (pins.mgmt_bus_alert_n),
      .gp_inputs           (pins.gp_inputs),
      .watchdog_timeout    (watchdog_timeout),
      .sw_reset_req        (sw_reset_req),
      .sw_sleep_req        (sw_sleep_req),
      .sw_off_req          (sw_off_req),
      .cpu_shutdown        (cpu_shutdown),
      .alert_wake_en       (alert_wake_en),
      .overtemp_clear      (overtemp_clear),
      .gp_out_value        (gp_out_value),
      .carrier_reset_out_n (carrier_reset_out_n),
      .suspend_imminent_n  (suspend_imminent_n),
      .suspend_ram_n       (suspend_ram_n),
      .suspend_disk_n      (suspend_disk_n),
      .soft_off_n          (soft_off_n),
      .thermal_trip_n      (thermal_trip_n),
      .mgmt_irq_n          (mgmt_irq_n),
      .battery_low_flag    (battery_low_flag),
      .overtemp_flag       (overtemp_flag),
      .gp_outputs          (gp_outputs),
      .gp_in_level         (gp_in_level)
   );

   always #2 clk = ~clk;

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   task automatic end_of_test;
      $display("counts: %0d comparisons, %0d miscompares",
               comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [3:0] exp,
                      input logic [3:0] got);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic sig(input int sel);
      case (sel)
         S_CARR:  return carrier_reset_out_n;
         S_RAM:   return suspend_ram_n;
         default: return soft_off_n;
      endcase
   endfunction

   // bounded wait, sampled at the falling edge where outputs are settled
   task automatic wait_sig(input int sel, input logic val, input int lim,
                           output int cnt);
      cnt = 0;
      while (sig(sel) !== val && cnt < lim)
      begin
         cyc(1);
         cnt++;
      end
      if (cnt >= lim)
      begin
         $display("[ERR] wait on signal %0d expected %b timed out", sel, val);
         miscompares++;
         end_of_test();
      end
   endtask

   // 0 button, 1 watchdog, 2 software, 3 power fail, 4 rail low
   task automatic cause(input int c, input logic v);
      case (c)
         0:       drv_low.reset_button_n = v;
         1:       watchdog_timeout = v;
         2:       sw_reset_req = v;
         3:       supply_ok = ~v;
         default: rail12_low = v;
      endcase
   endtask

   // 0 pcie, 1 general, 2 alert with wake enabled, 3 button (rises on v)
   task automatic wake(input int w, input logic v);
      case (w)
         0:       drv_low.pcie_wake_n = v;
         1:       drv_low.general_wake_n = v;
         2:       drv_low.mgmt_bus_alert_n = v;
         default: drv_low.power_button_n = ~v;
      endcase
   endtask

   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      supply_ok = 1'b1;
      rail12_low = 1'b0;
      drv_low = '0;
      {watchdog_timeout, sw_reset_req, sw_sleep_req, sw_off_req} = 4'h0;
      {cpu_shutdown, alert_wake_en, overtemp_clear} = 3'h0;
      gp_out_value = 4'h0;
      miscompares = 0;
      comparisons = 0;
      void'($urandom(32'h8973));
      cyc(3);
      reset_n = 1'b1;
      chk("soft_off_n", 4'h0, soft_off_n);
      chk("carrier_reset", 4'h0, carrier_reset_out_n);
      chk("suspend_disk_n", 4'h1, suspend_disk_n);
      chk("suspend_ram_n", 4'h1, suspend_ram_n);
      chk("imminent_n", 4'h1, suspend_imminent_n);
      chk("gp_outputs", 4'hF, gp_outputs);
      chk("gp_in_level", 4'hF, gp_in_level);
      $display("test reset values done");
      // a held-low button level must not leave soft-off
      drv_low.power_button_n = 1'b1;
      gp_out_value = 4'($urandom());
      cyc(20);
      chk("soft_off_n", 4'h0, soft_off_n);
      drv_low.power_button_n = 1'b0;
      wait_sig(S_SOFT, 1'b1, 20, n);
      chk("gp_outputs", 4'hF, gp_outputs);
      wait_sig(S_CARR, 1'b1, RSTC + 20, n);
      chk("pulse_ok", 4'h1, 4'(n >= RSTC - 8 && n <= RSTC + 2));
      cyc(2);
      chk("gp_outputs", gp_out_value, gp_outputs);
      $display("test power button done");
      for (int c = 0; c < 5; c++)
      begin
         cause(c, 1'b1);
         cyc(1);
         if (c == 1 || c == 2)
            cause(c, 1'b0);
         wait_sig(S_CARR, 1'b0, 12, n);
         if (c < 3)
         begin
            wait_sig(S_CARR, 1'b1, RSTC + 20, n);
            chk("pulse_ok", 4'h1, 4'(n >= RSTC - 8 && n <= RSTC + 2));
            cyc(20);
            chk("carrier_reset", 4'h1, carrier_reset_out_n);
         end
         else
         begin
            cyc(RSTC + 50);
            chk("carrier_reset", 4'h0, carrier_reset_out_n);
         end
         cause(c, 1'b0);
         wait_sig(S_CARR, 1'b1, RSTC + 20, n);
         cyc(10);
      end
      $display("test reset causes done");
      for (int w = 0; w < 4; w++)
      begin
         alert_wake_en = (w == 2);
         if (w == 3)
            wake(w, 1'b0);
         sw_sleep_req = 1'b1;
         cyc(1);
         sw_sleep_req = 1'b0;
         chk("imminent_n", 4'h0, suspend_imminent_n);
         chk("suspend_ram_n", 4'h1, suspend_ram_n);
         wait_sig(S_RAM, 1'b0, NOTC + 10, n);
         chk("notice_ok", 4'h1, 4'(n >= NOTC - 2 && n <= NOTC + 1));
         cyc(20);
         chk("suspend_ram_n", 4'h0, suspend_ram_n);
         chk("soft_off_n", 4'h1, soft_off_n);
         chk("suspend_disk_n", 4'h1, suspend_disk_n);
         wake(w, 1'b1);
         wait_sig(S_RAM, 1'b1, 12, n);
         chk("carrier_reset", 4'h0, carrier_reset_out_n);
         wake(w, 1'b0);
         wait_sig(S_CARR, 1'b1, RSTC + 20, n);
         cyc(10);
      end
      alert_wake_en = 1'b0;
      $display("test suspend and wake done");
      for (int i = 0; i < 12; i++)
      begin
         gp_old = ~drv_low.gp_inputs;
         drv_low.gp_inputs = 4'($urandom());
         drv_low.battery_low_n = 1'($urandom());
         drv_low.mgmt_bus_alert_n = (i < 2) ? 1'(i) : 1'($urandom());
         cpu_shutdown = (i < 2) ? 1'(i) : 1'($urandom());
         cyc(1);
         chk("gp_in_level_old", gp_old, gp_in_level);
         cyc(8);
         chk("gp_in_level", ~drv_low.gp_inputs, gp_in_level);
         chk("battery_low", drv_low.battery_low_n, battery_low_flag);
         chk("mgmt_irq_n", !drv_low.mgmt_bus_alert_n, mgmt_irq_n);
         chk("thermal_trip", !cpu_shutdown, thermal_trip_n);
      end
      drv_low = '0;
      cpu_shutdown = 1'b0;
      chk("overtemp_flag", 4'h0, overtemp_flag);
      drv_low.overtemp_in_n = 1'b1;
      cyc(10);
      // a clear while the sensor still reports must lose
      overtemp_clear = 1'b1;
      cyc(1);
      overtemp_clear = 1'b0;
      chk("overtemp_flag", 4'h1, overtemp_flag);
      drv_low.overtemp_in_n = 1'b0;
      cyc(10);
      chk("overtemp_flag", 4'h1, overtemp_flag);
      overtemp_clear = 1'b1;
      cyc(1);
      overtemp_clear = 1'b0;
      cyc(2);
      chk("overtemp_flag", 4'h0, overtemp_flag);
      $display("test status inputs done");
      sw_off_req = 1'b1;
      cyc(1);
      sw_off_req = 1'b0;
      chk("imminent_n", 4'h0, suspend_imminent_n);
      wait_sig(S_SOFT, 1'b0, NOTC + 10, n);
      cyc(20);
      chk("soft_off_n", 4'h0, soft_off_n);
      drv_low.pcie_wake_n = 1'b1;
      cyc(20);
      chk("soft_off_n", 4'h0, soft_off_n);
      // power button again, then off request straight from suspend
      drv_low.power_button_n = 1'b1;
      cyc(10);
      drv_low.power_button_n = 1'b0;
      wait_sig(S_CARR, 1'b1, RSTC + 20, n);
      sw_sleep_req = 1'b1;
      cyc(1);
      sw_sleep_req = 1'b0;
      wait_sig(S_RAM, 1'b0, NOTC + 10, n);
      sw_off_req = 1'b1;
      cyc(1);
      sw_off_req = 1'b0;
      cyc(1);
      chk("soft_off_n", 4'h0, soft_off_n);
      chk("suspend_ram_n", 4'h1, suspend_ram_n);
      $display("test soft off done");
      end_of_test();
   end
endmodule
